// ==== src/ewp_port_pair.sv ====
// Wake-up port pair: two 8-bit ports, edge flags, shared filter and request
`timescale 1ns/1ps
`default_nettype none
module ewp_port_pair
  import ewp_pkg::*;
#(
  parameter int WIDTH    = 8,
  parameter int FILT_DIV = EWP_FILT_DIV_DEFAULT
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Power state
  input  wire logic              deep_halt,
  // Pins of port J
  input  wire logic [WIDTH-1:0]  pin_j_in,
  output logic      [WIDTH-1:0]  pin_j_out,
  output logic      [WIDTH-1:0]  pin_j_oe,
  output logic      [WIDTH-1:0]  pin_j_pullup,
  output logic      [WIDTH-1:0]  pin_j_pulldown,
  // Pins of port H
  input  wire logic [WIDTH-1:0]  pin_h_in,
  output logic      [WIDTH-1:0]  pin_h_out,
  output logic      [WIDTH-1:0]  pin_h_oe,
  output logic      [WIDTH-1:0]  pin_h_pullup,
  output logic      [WIDTH-1:0]  pin_h_pulldown,
  // Wake-up request
  output logic                   wake_irq,
  output logic                   wake_cpu
);

  localparam int N = 2 * WIDTH;

  typedef enum logic [1:0] {
    EWP_BUS_IDLE = 2'b00,
    EWP_BUS_ACK  = 2'b01
  } ewp_bus_t;

  typedef enum logic [1:0] {
    EWP_FLT_IDLE = 2'b00,
    EWP_FLT_RUN  = 2'b01,
    EWP_FLT_DONE = 2'b11
  } ewp_flt_t;

  // Register state, H in upper half, J in lower half
  logic [N-1:0] data_reg,  data_next;
  logic [N-1:0] dir_reg,   dir_next;
  logic [N-1:0] en_reg,    en_next;
  logic [N-1:0] flag_reg,  flag_next;
  logic [N-1:0] pol_reg,   pol_next;
  logic [31:0]  rdata_reg, rdata_next;
  ewp_bus_t     bus_reg,   bus_next;

  // Pin sampling
  logic [N-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [N-1:0] pins_all;
  logic [N-1:0] lvl_eff;
  logic [N-1:0] lvl_prev;
  logic [N-1:0] edge_set;

  // Filter
  ewp_flt_t     flt_reg,   flt_next;
  logic [N-1:0] cand_reg,  cand_next;
  logic [15:0]  div_reg,   div_next;
  logic [1:0]   smp_reg,   smp_next;
  logic [1:0]   hit_reg,   hit_next;
  logic [N-1:0] filt_set;
  logic [N-1:0] async_trig;

  // Bus decode
  logic         acc;
  logic [7:0]   wbyte;
  logic         hit_h;

  assign pins_all = {pin_h_in, pin_j_in};

  // Active level, normalised: 1 means the triggering level
  assign lvl_eff  = sync2_reg ~^ pol_reg;
  assign lvl_prev = prev_reg ~^ pol_reg;

  // Edge detection works for any direction setting
  assign edge_set = deep_halt ? filt_set : (lvl_eff & ~lvl_prev);

  // Raw enabled triggering level, no clocked element in this path
  assign async_trig = (pins_all ~^ pol_reg) & en_reg;

  // Shared request for all sixteen sources
  assign wake_irq = |(flag_reg & en_reg);
  assign wake_cpu = wake_irq | (deep_halt & (|async_trig));

  // Pin drive and pull selection
  assign pin_j_out      = data_reg[WIDTH-1:0];
  assign pin_h_out      = data_reg[N-1:WIDTH];
  assign pin_j_oe       = dir_reg[WIDTH-1:0];
  assign pin_h_oe       = dir_reg[N-1:WIDTH];
  assign pin_j_pullup   = ~pol_reg[WIDTH-1:0]  & ~dir_reg[WIDTH-1:0];
  assign pin_h_pullup   = ~pol_reg[N-1:WIDTH]  & ~dir_reg[N-1:WIDTH];
  assign pin_j_pulldown = pol_reg[WIDTH-1:0]   & ~dir_reg[WIDTH-1:0];
  assign pin_h_pulldown = pol_reg[N-1:WIDTH]   & ~dir_reg[N-1:WIDTH];

  assign acc             = (bus_reg == EWP_BUS_IDLE) & (avs_read | avs_write);
  assign avs_waitrequest = (bus_reg == EWP_BUS_IDLE);
  assign avs_readdata    = rdata_reg;
  assign hit_h           = avs_address[0];
  assign wbyte           = avs_byteenable[avs_address[1:0]] ?
                           avs_writedata[{avs_address[1:0], 3'b000} +: 8] : 8'h00;

  // Pin synchroniser and previous-sample register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end
    else
    begin
      sync1_reg <= pins_all;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Shared majority-vote filter, active only in deep halt
  always_comb
  begin
    flt_next  = flt_reg;
    cand_next = cand_reg;
    div_next  = div_reg;
    smp_next  = smp_reg;
    hit_next  = hit_reg;
    filt_set  = '0;
    case (flt_reg)
      EWP_FLT_IDLE:
      begin
        if (deep_halt && |(lvl_eff & ~lvl_prev & en_reg))
        begin
          flt_next  = EWP_FLT_RUN;
          cand_next = lvl_eff & ~lvl_prev & en_reg;
          div_next  = '0;
          smp_next  = '0;
          hit_next  = '0;
        end
      end
      EWP_FLT_RUN:
      begin
        if (!deep_halt)
          flt_next = EWP_FLT_IDLE;
        else if (div_reg == 16'(FILT_DIV - 1))
        begin
          div_next  = '0;
          // Merge late pins into the same window
          cand_next = cand_reg | (lvl_eff & en_reg);
          if (|(lvl_eff & cand_reg))
            hit_next = hit_reg + 2'h1;
          smp_next = smp_reg + 2'h1;
          if (smp_reg == 2'(EWP_VOTE_SAMPLES - 1))
            flt_next = EWP_FLT_DONE;
        end
        else
          div_next = div_reg + 16'h0001;
      end
      EWP_FLT_DONE:
      begin
        if (hit_reg >= EWP_VOTE_NEEDED)
          filt_set = cand_reg;
        flt_next  = EWP_FLT_IDLE;
        cand_next = '0;
      end
      default:
        flt_next = EWP_FLT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flt_reg  <= EWP_FLT_IDLE;
      cand_reg <= '0;
      div_reg  <= '0;
      smp_reg  <= '0;
      hit_reg  <= '0;
    end
    else
    begin
      flt_reg  <= flt_next;
      cand_reg <= cand_next;
      div_reg  <= div_next;
      smp_reg  <= smp_next;
      hit_reg  <= hit_next;
    end
  end

  // Register file and bus answer
  always_comb
  begin
    data_next  = data_reg;
    dir_next   = dir_reg;
    en_next    = en_reg;
    pol_next   = pol_reg;
    flag_next  = flag_reg;
    rdata_next = rdata_reg;
    bus_next   = EWP_BUS_IDLE;
    if (acc)
    begin
      bus_next   = EWP_BUS_ACK;
      rdata_next = 32'h0000_0000;
      if (avs_read)
      begin
        if (avs_address[7:1] == EWP_PORT_J_DATA_OFS[7:1])
          rdata_next = {16'h0000,
                        dir_reg[N-1:WIDTH] & data_reg[N-1:WIDTH] |
                        ~dir_reg[N-1:WIDTH] & sync2_reg[N-1:WIDTH],
                        dir_reg[WIDTH-1:0] & data_reg[WIDTH-1:0] |
                        ~dir_reg[WIDTH-1:0] & sync2_reg[WIDTH-1:0]};
        else if (avs_address[7:1] == EWP_PORT_J_DIR_OFS[7:1])
          rdata_next = {16'h0000, dir_reg};
        else if (avs_address[7:1] == EWP_WAKE_EN_J_OFS[7:1])
          rdata_next = {16'h0000, en_reg};
        else if (avs_address[7:1] == EWP_WAKE_FLAG_J_OFS[7:1])
          rdata_next = {16'h0000, flag_reg};
        else if (avs_address[7:1] == EWP_EDGE_SEL_J_OFS[7:1])
          rdata_next = {16'h0000, pol_reg};
        if (hit_h)
          rdata_next = {24'h000000, rdata_next[15:8]};
        else
          rdata_next = {24'h000000, rdata_next[7:0]};
      end
    end
    // A write takes effect only at the edge where waitrequest is sampled low
    if ((bus_reg == EWP_BUS_ACK) && avs_write && !avs_read)
    begin
      begin
        if (avs_address[7:1] == EWP_PORT_J_DATA_OFS[7:1])
          data_next[{hit_h, 3'b000} +: 8] = wbyte;
        else if (avs_address[7:1] == EWP_PORT_J_DIR_OFS[7:1])
          dir_next[{hit_h, 3'b000} +: 8] = wbyte;
        else if (avs_address[7:1] == EWP_WAKE_EN_J_OFS[7:1])
          en_next[{hit_h, 3'b000} +: 8] = wbyte;
        else if (avs_address[7:1] == EWP_WAKE_FLAG_J_OFS[7:1])
          flag_next[{hit_h, 3'b000} +: 8] = flag_reg[{hit_h, 3'b000} +: 8] & ~wbyte;
        else if (avs_address[7:1] == EWP_EDGE_SEL_J_OFS[7:1])
          pol_next[{hit_h, 3'b000} +: 8] = wbyte;
      end
    end
    // Set wins over a clearing write in the same cycle
    flag_next = flag_next | edge_set;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_reg  <= '0;
      dir_reg   <= '0;
      en_reg    <= '0;
      flag_reg  <= '0;
      pol_reg   <= '0;
      rdata_reg <= '0;
      bus_reg   <= EWP_BUS_IDLE;
    end
    else
    begin
      data_reg  <= data_next;
      dir_reg   <= dir_next;
      en_reg    <= en_next;
      flag_reg  <= flag_next;
      pol_reg   <= pol_next;
      rdata_reg <= rdata_next;
      bus_reg   <= bus_next;
    end
  end

endmodule // ewp_port_pair
`default_nettype wire

// ==== src/ewp_pkg.sv ====
// Package: register map, reset values and filter constants of the wake-up port pair
// Functional notes
// - Two 8-bit ports, sixteen wake-capable pins
// - Pending wake-up wakes from halt and wait
// - Unclocked pin-to-request path in deep halt
// - Request when any flag and enable set
// - All sixteen sources share one request
// - Edge detection works for inputs and outputs
// - Direction: 0 input, 1 output, reset 0
// - Enable: 1 enables, 0 disables, reset 0
// - Polarity-selected edge sets flag, reset 0
// - Writing one clears the flag
// - Polarity 0 falling/pull-up, 1 rising/pull-down
// - Changing polarity may set the flag; here it does not, as both samples compare against the same pol_reg
// - Filter active only in deep halt
// - Filter oscillator starts on enabled edge
// - Three samples, two valid sets flag
// - One filter shared by enabled pins
// - Close pulses may merge into one
package ewp_pkg;
  localparam logic [7:0] EWP_PORT_J_DATA_OFS  = 8'h28;
  localparam logic [7:0] EWP_PORT_H_DATA_OFS  = 8'h29;
  localparam logic [7:0] EWP_PORT_J_DIR_OFS   = 8'h2A;
  localparam logic [7:0] EWP_PORT_H_DIR_OFS   = 8'h2B;
  localparam logic [7:0] EWP_WAKE_EN_J_OFS    = 8'h2C;
  localparam logic [7:0] EWP_WAKE_EN_H_OFS    = 8'h2D;
  localparam logic [7:0] EWP_WAKE_FLAG_J_OFS  = 8'h2E;
  localparam logic [7:0] EWP_WAKE_FLAG_H_OFS  = 8'h2F;
  localparam logic [7:0] EWP_EDGE_SEL_J_OFS   = 8'h30;
  localparam logic [7:0] EWP_EDGE_SEL_H_OFS   = 8'h31;
  localparam logic [7:0] EWP_REG_RESET        = 8'h00;
  localparam int         EWP_VOTE_SAMPLES     = 3;
  localparam logic [1:0] EWP_VOTE_NEEDED      = 2'h2;
  localparam int         EWP_FILT_DIV_DEFAULT = 4;
endpackage

// ==== dv/ewp_pin_model.sv ====
// Far-side pin model: output drivers win, otherwise the external key drives the pin
`timescale 1ns/1ps
`default_nettype none
module ewp_pin_model
#(
  parameter int WIDTH = 8
)
(
  // Device side
  input  wire logic [WIDTH-1:0] oe,
  input  wire logic [WIDTH-1:0] out,
  // External keys
  input  wire logic [WIDTH-1:0] key,
  // Resolved pin level
  output logic      [WIDTH-1:0] pin
);
  assign pin = (oe & out) | (~oe & key);
endmodule // ewp_pin_model
`default_nettype wire

// ==== dv/ewp_port_pair_checker.sv ====
// Port-level assertions for the wake-up port pair
`timescale 1ns/1ps
`default_nettype none
module ewp_port_pair_checker
  import ewp_pkg::*;
#(
  parameter int WIDTH    = 8,
  parameter int FILT_DIV = 4
)
(
  input wire logic             clk_sys,
  input wire logic             rst_b,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  input wire logic             deep_halt,
  input wire logic [WIDTH-1:0] pin_j_oe,
  input wire logic [WIDTH-1:0] pin_j_pullup,
  input wire logic [WIDTH-1:0] pin_j_pulldown,
  input wire logic [WIDTH-1:0] pin_h_oe,
  input wire logic [WIDTH-1:0] pin_h_pullup,
  input wire logic [WIDTH-1:0] pin_h_pulldown,
  input wire logic             wake_irq,
  input wire logic             wake_cpu
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in the next cycle");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  a_j_pulls: assert property ((pin_j_pullup | pin_j_pulldown | pin_j_oe) == {WIDTH{1'b1}}
    && ((pin_j_pullup & pin_j_pulldown) | (pin_j_oe & (pin_j_pullup | pin_j_pulldown))) == '0)
    else $error("port J pull selection wrong");
  a_h_pulls: assert property ((pin_h_pullup | pin_h_pulldown | pin_h_oe) == {WIDTH{1'b1}}
    && ((pin_h_pullup & pin_h_pulldown) | (pin_h_oe & (pin_h_pullup | pin_h_pulldown))) == '0)
    else $error("port H pull selection wrong");
  a_irq_wakes: assert property (wake_irq |-> wake_cpu)
    else $error("pending request does not wake the processor");
  a_run_wake: assert property (!deep_halt |-> wake_cpu == wake_irq)
    else $error("raw wake path active outside deep halt");
  a_irq_holds: assert property (wake_irq && !(avs_write && !avs_waitrequest) |=> wake_irq)
    else $error("request dropped without a register write");
endmodule // ewp_port_pair_checker
bind ewp_port_pair ewp_port_pair_checker #(.WIDTH(WIDTH), .FILT_DIV(FILT_DIV)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .deep_halt(deep_halt),
  .pin_j_oe(pin_j_oe), .pin_j_pullup(pin_j_pullup), .pin_j_pulldown(pin_j_pulldown),
  .pin_h_oe(pin_h_oe), .pin_h_pullup(pin_h_pullup), .pin_h_pulldown(pin_h_pulldown),
  .wake_irq(wake_irq), .wake_cpu(wake_cpu));
`default_nettype wire

// ==== dv/edge_wake_port_pair_bench.sv ====
// Self-checking bench for the wake-up port pair
`timescale 1ns/1ps
`default_nettype none
module edge_wake_port_pair_bench;
  import ewp_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, rdq = 1'b0, wrq = 1'b0, deep_halt = 1'b0;
  logic [7:0]  adr = 8'h00, key_j = 8'hFF, key_h = 8'h00, r;
  logic [31:0] wdat = 32'h0, avs_readdata;
  logic        avs_waitrequest, wake_irq, wake_cpu;
  logic [7:0]  pj_in, pj_out, pj_oe, pj_pu, pj_pd, ph_in, ph_out, ph_oe, ph_pu, ph_pd;
  logic [7:0]  ofs [6] = '{8'h2A, 8'h2C, 8'h2E, 8'h30, 8'h31, 8'h40};
  int          mismatches = 0, checks = 0;
  always #10 clk_sys = ~clk_sys;
  ewp_port_pair #(.WIDTH(8), .FILT_DIV(2)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(adr), .avs_read(rdq), .avs_write(wrq),
    .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .deep_halt(deep_halt),
    .pin_j_in(pj_in), .pin_j_out(pj_out), .pin_j_oe(pj_oe), .pin_j_pullup(pj_pu),
    .pin_j_pulldown(pj_pd), .pin_h_in(ph_in), .pin_h_out(ph_out), .pin_h_oe(ph_oe),
    .pin_h_pullup(ph_pu), .pin_h_pulldown(ph_pd), .wake_irq(wake_irq), .wake_cpu(wake_cpu));
  ewp_pin_model #(.WIDTH(8)) u_pins_j (.oe(pj_oe), .out(pj_out), .key(key_j), .pin(pj_in));
  ewp_pin_model #(.WIDTH(8)) u_pins_h (.oe(ph_oe), .out(ph_out), .key(key_h), .pin(ph_in));
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    adr  <= a;
    wdat <= {4{d}};
    wrq  <= w;
    rdq  <= ~w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    wrq <= 1'b0;
    rdq <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(a, 1'b1, d);
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    access(a, 1'b0, 8'h00);
    chk(r, exp);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(ofs[i], 8'h00);
    wr(8'h2A, 8'hA5);
    rdchk(8'h2A, 8'hA5);
    chk(pj_oe, 8'hA5);
    chk(pj_pu, 8'h5A);
    wr(8'h2A, 8'h00);
    wr(8'h2D, 8'h3C);
    rdchk(8'h2D, 8'h3C);
    wr(8'h2D, 8'h00);
    // Falling edge on J3 with the enable still off
    wr(8'h2E, 8'hFF);
    key_j <= 8'hF7;
    settle();
    rdchk(8'h2E, 8'h08);
    chk({7'h0, wake_irq}, 8'h00);
    wr(8'h2C, 8'h08);
    chk({7'h0, wake_irq}, 8'h01);
    wr(8'h2E, 8'h00);
    rdchk(8'h2E, 8'h08);
    wr(8'h2E, 8'h08);
    rdchk(8'h2E, 8'h00);
    chk({7'h0, wake_irq}, 8'h00);
    // Rising polarity on port H, flags cleared after the polarity change
    wr(8'h31, 8'hFF);
    chk(ph_pd, 8'hFF);
    wr(8'h2F, 8'hFF);
    wr(8'h2D, 8'h01);
    key_h <= 8'h01;
    settle();
    chk({7'h0, wake_irq}, 8'h01);
    rdchk(8'h2F, 8'h01);
    wr(8'h2F, 8'h01);
    key_h <= 8'h00;
    settle();
    rdchk(8'h2F, 8'h00);
    wr(8'h2D, 8'h00);
    // Edge produced by the port's own output driver
    wr(8'h28, 8'h01);
    wr(8'h2A, 8'h01);
    wr(8'h2E, 8'hFF);
    wr(8'h28, 8'h00);
    settle();
    rdchk(8'h2E, 8'h01);
    wr(8'h2A, 8'h00);
    wr(8'h2C, 8'h02);
    wr(8'h2E, 8'hFF);
    // Deep halt: short pulse wakes raw path but is filtered out, long pulse sets flag
    deep_halt <= 1'b1;
    @(posedge clk_sys);
    key_j <= 8'hF5;
    @(posedge clk_sys);
    chk({7'h0, wake_cpu}, 8'h01);
    key_j <= 8'hF7;
    repeat (10) @(posedge clk_sys);
    rdchk(8'h2E, 8'h00);
    key_j <= 8'hF5;
    repeat (20) @(posedge clk_sys);
    rdchk(8'h2E, 8'h02);
    deep_halt <= 1'b0;
    key_j <= 8'hF7;
    complete_run();
  end
endmodule // edge_wake_port_pair_bench
`default_nettype wire
